// [design/gpioc_defines.svh]
`ifndef GPIOC_DEFINES_SVH
`define GPIOC_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define GPIOC_ADDR_INSTR 8'h00
`define GPIOC_ADDR_ACC 8'h04
`define GPIOC_ADDR_RESULT 8'h08
`define GPIOC_ADDR_STATUS 8'h0c

// ==========================================================
// Instruction fields (instruction bit 0 is word bit 15)
`define GPIOC_F_OPCODE 15:13
`define GPIOC_F_XFER 10:8
`define GPIOC_F_FLAG 7:6
`define GPIOC_F_DEV 5:0
`define GPIOC_IO_OPCODE 3'h3
`define GPIOC_CPU_DEV 6'h3f

// ==========================================================
// Flag functions and skip tests
`define GPIOC_FN_START 2'h1
`define GPIOC_FN_CLEAR 2'h2
`define GPIOC_FN_PULSE 2'h3
`define GPIOC_T_BUSY_SET 2'h0
`define GPIOC_T_BUSY_ZERO 2'h1
`define GPIOC_T_DONE_SET 2'h2
`define GPIOC_T_DONE_ZERO 2'h3

// ==========================================================
// Status and result fields
`define GPIOC_S_BUSY 0
`define GPIOC_S_DONE 1
`define GPIOC_S_INTREQ 2
`define GPIOC_S_INTDIS 3
`define GPIOC_S_SYNCPEND 4
`define GPIOC_S_ACTIVE 5
`define GPIOC_S_POSITIVE 6
`define GPIOC_S_EXTERNAL 7
`define GPIOC_S_DEV 13:8
`define GPIOC_R_WORD 15:0
`define GPIOC_R_SKIP 16

// ==========================================================
// Reset values and timing
`define GPIOC_RST_WORD 16'h0000
`define GPIOC_JUMPER_LOADS 2'h3
`define GPIOC_SETTLE_NS 60
`define GPIOC_CLK_MHZ 50
`define GPIOC_SETTLE_CYC ((`GPIOC_SETTLE_NS * `GPIOC_CLK_MHZ + 999) / 1000)

`endif

// [design/gpioc_pkg.sv]
package gpioc_pkg;

  // ========================================================
  // Sequencer and decode types
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD = 2'h1,
    ST_XFER = 2'h3,
    ST_FLAG = 2'h2
  } gpioc_seq_type;

  typedef enum logic [2:0] {
    XF_NONE = 3'h0,
    XF_IN_A = 3'h1,
    XF_OUT_A = 3'h2,
    XF_IN_B = 3'h3,
    XF_OUT_B = 3'h4,
    XF_IN_C = 3'h5,
    XF_OUT_C = 3'h6,
    XF_SKIP = 3'h7
  } gpioc_xfer_type;

  typedef struct packed {
    logic inputAStrobe;
    logic inputBStrobe;
    logic inputCStrobe;
    logic outputAStrobe;
    logic outputBStrobe;
    logic outputCStrobe;
    logic maskLoadStrobe;
    logic startStrobe;
    logic clearStrobe;
    logic specialPulseStrobe;
  } gpioc_strobe_type;

  typedef struct packed {
    gpioc_seq_type st;
    logic [2:0] settle;
    logic [15:0] instr;
    logic [15:0] acc;
    logic [15:0] result;
    logic skip;
    logic cpu;
    logic busy;
    logic done;
    logic intDisable;
    logic syncPend;
    logic intReq;
    logic [5:0] devCode;
    logic positive;
    logic external;
    logic [1:0] loadCnt;
    logic [14:0] chAddr;
    logic [15:0] count;
    logic [15:0] dataOut;
    gpioc_strobe_type strobes;
    logic [31:0] prdata;
  } gpioc_state_type;

endpackage

// [design/gpioc_sync.sv]
`timescale 1ns/1ps
module gpioc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [design/gpioc_controller.sv]
// How it works
// - Start function sets busy, clears done, pulses start strobe.
// - Clear function clears busy and done, pulses clear strobe.
// - Pulse function clears done only, pulses special strobe.
// - Command strobe first, then data transfer, then flag function.
// - No-transfer instruction moves no data, only runs flag function.
// - Input strobe; customer drives lines; sampled word returned.
// - Output strobe; accumulator word driven on output lines.
// - Skip test reports whether the requested flag condition holds.
// - Bus reset clears busy, done; reloads code and polarity.
// - Mask load: AND input lines with accumulator sets disable.
// - Acknowledge returns device code only if requesting and first.
// - Device code sits in bits 10-15; fitted jumper reads one.
// - Without outside registers, internal address serves channel.
// - Sense jumper fitted means positive logic, else negative.
// - Address register writable and readable, count write-only.
// - Address register 15 bits, word count register 16 bits.
// - Strobes up to three output and three input registers.
// - Output words on output group, input words on input group.
// - Flag field: 01 start, 10 clear, 11 pulse, 00 none.
// - Done request sets done, clears busy; busy request sets busy.
// - Sync request raises interrupt without touching busy or done.
`timescale 1ns/1ps
`include "gpioc_defines.svh"
module gpioc_controller (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Customer data lines
  output logic [15:0] dataOutLines,
  input wire logic [15:0] dataInLines,
  // Customer strobes and requests
  output gpioc_pkg::gpioc_strobe_type strobes,
  input wire logic setBusyReq,
  input wire logic setDoneReq,
  input wire logic intSyncReq,
  // Configuration jumpers
  input wire logic [5:0] deviceCodeJumpers,
  input wire logic outsideRegisterJumper,
  input wire logic logicSenseJumper,
  // Interrupt chain and data channel
  input wire logic noHigherRequest,
  output logic intRequest,
  output logic [14:0] channelAddress,
  output logic channelAddressInternal,
  output logic [15:0] channelCount
);
  import gpioc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  localparam int SYNC_W = 27;
  localparam logic [2:0] SETTLE = 3'(`GPIOC_SETTLE_CYC);

  gpioc_state_type q;
  gpioc_state_type d;
  logic [SYNC_W-1:0] rawPins;
  logic [SYNC_W-1:0] syncPins;
  logic [15:0] linesS;
  logic setBusyS;
  logic setDoneS;
  logic intSyncS;
  logic [5:0] jumpS;
  logic outsideS;
  logic senseS;
  logic regWrite;
  logic instrWrite;
  gpioc_xfer_type xfer;
  logic [1:0] flagFn;

  assign rawPins = {dataInLines, setBusyReq, setDoneReq, intSyncReq,
                    deviceCodeJumpers, outsideRegisterJumper,
                    logicSenseJumper};

  gpioc_sync #(.WIDTH(SYNC_W)) pinSync (
    .clk(clk),
    .rstn(rstn),
    .din(rawPins),
    .dout(syncPins)
  );

  assign {linesS, setBusyS, setDoneS, intSyncS, jumpS, outsideS,
          senseS} = syncPins;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] sense(input logic [15:0] w,
                                        input logic positive);
    return positive ? w : ~w;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `GPIOC_ADDR_INSTR || a == `GPIOC_ADDR_ACC ||
           a == `GPIOC_ADDR_RESULT || a == `GPIOC_ADDR_STATUS;
  endfunction

  function automatic logic skip_true(input logic [1:0] t,
                                     input logic busy,
                                     input logic done);
    logic r;
    r = 1'h0;
    unique case (t)
      `GPIOC_T_BUSY_SET: r = busy;
      `GPIOC_T_BUSY_ZERO: r = ~busy;
      `GPIOC_T_DONE_SET: r = done;
      `GPIOC_T_DONE_ZERO: r = ~done;
    endcase
    return r;
  endfunction

  // Whether an instruction word is one this controller acts on
  function automatic logic accepted(input logic [15:0] w,
                                    input logic [5:0] own);
    logic io;
    logic cpuOp;
    io = w[`GPIOC_F_OPCODE] == `GPIOC_IO_OPCODE;
    cpuOp = w[`GPIOC_F_DEV] == `GPIOC_CPU_DEV &&
            (w[`GPIOC_F_XFER] == XF_OUT_A ||
             w[`GPIOC_F_XFER] == XF_OUT_B ||
             w[`GPIOC_F_XFER] == XF_IN_B);
    return io && (cpuOp || w[`GPIOC_F_DEV] == own);
  endfunction

  function automatic gpioc_strobe_type data_strobes(input logic [15:0] w);
    gpioc_strobe_type s;
    logic cpuDev;
    s = '0;
    cpuDev = w[`GPIOC_F_DEV] == `GPIOC_CPU_DEV;
    unique case (gpioc_xfer_type'(w[`GPIOC_F_XFER]))
      XF_IN_A: s.inputAStrobe = 1'h1;
      XF_IN_B: s.inputBStrobe = ~cpuDev;
      XF_IN_C: s.inputCStrobe = 1'h1;
      XF_OUT_A: s.outputAStrobe = ~cpuDev;
      XF_OUT_B: begin
        s.outputBStrobe = ~cpuDev;
        s.maskLoadStrobe = cpuDev;
      end
      XF_OUT_C: s.outputCStrobe = 1'h1;
      XF_NONE, XF_SKIP: s = '0;
    endcase
    return s;
  endfunction

  assign regWrite = psel & penable & pwrite & is_mapped(paddr);
  assign instrWrite = regWrite && paddr == `GPIOC_ADDR_INSTR;
  assign xfer = gpioc_xfer_type'(q.instr[`GPIOC_F_XFER]);
  assign flagFn = q.instr[`GPIOC_F_FLAG];

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] inWord;
    logic ackHit;
    inWord = sense(linesS, q.positive);
    ackHit = q.intReq & noHigherRequest;
    d = q;

    // Accumulator is only writable between instructions
    if (regWrite && paddr == `GPIOC_ADDR_ACC && q.st == ST_IDLE) begin
      d.acc = pwdata[15:0];
    end

    unique case (q.st)
      ST_IDLE: begin
        if (instrWrite && accepted(pwdata[15:0], q.devCode)) begin
          d.instr = pwdata[15:0];
          d.cpu = pwdata[`GPIOC_F_DEV] == `GPIOC_CPU_DEV;
          d.settle = SETTLE;
          d.strobes = data_strobes(pwdata[15:0]);
          d.st = ST_CMD;
        end
      end
      ST_CMD: begin
        // Wait for the customer to drive and for the input sync
        if (q.settle == 3'h0) begin
          d.st = ST_XFER;
        end else begin
          d.settle = q.settle - 3'h1;
        end
      end
      ST_XFER: begin
        d.st = ST_FLAG;
        d.strobes = '0;
        if (q.cpu) begin
          unique case (xfer)
            XF_OUT_A: begin
              d.busy = 1'h0;
              d.done = 1'h0;
              d.syncPend = 1'h0;
              d.devCode = jumpS;
              d.external = outsideS;
              d.positive = senseS;
            end
            XF_OUT_B: d.intDisable = |(inWord & q.acc);
            XF_IN_B: begin
              d.result = ackHit ? {10'h000, q.devCode} : 16'h0000;
              if (ackHit) begin
                d.syncPend = 1'h0;
              end
            end
            default: d.result = q.result;
          endcase
        end else begin
          unique case (xfer)
            XF_IN_A, XF_IN_C: d.result = inWord;
            XF_IN_B: d.result = q.external ? inWord :
                                {1'h0, q.chAddr};
            XF_OUT_A: d.dataOut = sense(q.acc, q.positive);
            XF_OUT_B: begin
              d.dataOut = sense(q.acc, q.positive);
              d.chAddr = q.acc[14:0];
            end
            XF_OUT_C: begin
              d.dataOut = sense(q.acc, q.positive);
              d.count = q.acc;
            end
            XF_SKIP: d.skip = skip_true(flagFn, q.busy, q.done);
            XF_NONE: d.result = q.result;
          endcase
          if (xfer != XF_SKIP) begin
            d.strobes.startStrobe = flagFn == `GPIOC_FN_START;
            d.strobes.clearStrobe = flagFn == `GPIOC_FN_CLEAR;
            d.strobes.specialPulseStrobe = flagFn == `GPIOC_FN_PULSE;
          end
        end
      end
      ST_FLAG: begin
        // Flags change after the transfer, at the edge that ends the flag strobe
        d.st = ST_IDLE;
        d.strobes = '0;
        if (!q.cpu && xfer != XF_SKIP) begin
          unique case (flagFn)
            `GPIOC_FN_START: begin
              d.busy = 1'h1;
              d.done = 1'h0;
            end
            `GPIOC_FN_CLEAR: begin
              d.busy = 1'h0;
              d.done = 1'h0;
            end
            `GPIOC_FN_PULSE: d.done = 1'h0;
            default: d.done = q.done;
          endcase
        end
      end
    endcase

    // Customer requests win over any clear in the same cycle
    if (setDoneS) begin
      d.done = 1'h1;
      d.busy = 1'h0;
    end
    if (setBusyS) begin
      d.busy = 1'h1;
    end
    if (intSyncS) begin
      d.syncPend = 1'h1;
    end
    d.intReq = ~d.intDisable & (d.done | d.syncPend);

    // Jumpers load on the first three clocks after reset; only the last sees synchronised levels
    if (q.loadCnt != 2'h0) begin
      d.loadCnt = q.loadCnt - 2'h1;
      d.devCode = jumpS;
      d.external = outsideS;
      d.positive = senseS;
    end

    if (psel && !penable) begin
      d.prdata = 32'h0000_0000;
      case (paddr)
        `GPIOC_ADDR_INSTR: d.prdata[15:0] = q.instr;
        `GPIOC_ADDR_ACC: d.prdata[15:0] = q.acc;
        `GPIOC_ADDR_RESULT: begin
          d.prdata[`GPIOC_R_WORD] = q.result;
          d.prdata[`GPIOC_R_SKIP] = q.skip;
        end
        `GPIOC_ADDR_STATUS: begin
          d.prdata[`GPIOC_S_BUSY] = q.busy;
          d.prdata[`GPIOC_S_DONE] = q.done;
          d.prdata[`GPIOC_S_INTREQ] = q.intReq;
          d.prdata[`GPIOC_S_INTDIS] = q.intDisable;
          d.prdata[`GPIOC_S_SYNCPEND] = q.syncPend;
          d.prdata[`GPIOC_S_ACTIVE] = q.st != ST_IDLE;
          d.prdata[`GPIOC_S_POSITIVE] = q.positive;
          d.prdata[`GPIOC_S_EXTERNAL] = q.external;
          d.prdata[`GPIOC_S_DEV] = q.devCode;
        end
        default: d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.loadCnt <= `GPIOC_JUMPER_LOADS;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = q.prdata;
  assign pready = 1'h1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign dataOutLines = q.dataOut;
  assign strobes = q.strobes;
  assign intRequest = q.intReq;
  assign channelAddress = q.chAddr;
  assign channelAddressInternal = ~q.external;
  assign channelCount = q.count;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic dataAny;
  logic flagAny;
  logic ownFlag;
  assign dataAny = |q.strobes[9:3];
  assign flagAny = |q.strobes[2:0];
  assign ownFlag = q.st == ST_FLAG && !q.cpu && xfer != XF_SKIP;

  a_start_flags: assert property (
    (ownFlag && flagFn == `GPIOC_FN_START && !setDoneS) |=>
      (q.busy && !q.done))
    else $error("start function did not set busy and clear done");
  a_clear_flags: assert property (
    (ownFlag && flagFn == `GPIOC_FN_CLEAR && !setDoneS && !setBusyS)
      |=> (!q.busy && !q.done))
    else $error("clear function left a flag set");
  a_pulse_flags: assert property (
    (ownFlag && flagFn == `GPIOC_FN_PULSE && !setDoneS && !setBusyS)
      |=> (!q.done && q.busy == $past(q.busy)))
    else $error("pulse function changed busy or kept done");
  a_flag_after_data: assert property (
    flagAny |-> (q.st == ST_FLAG && !dataAny && $past(q.st) == ST_XFER))
    else $error("flag strobe outside the flag step");
  a_strobe_first: assert property (
    (q.st == ST_IDLE && instrWrite && accepted(pwdata[15:0], q.devCode))
      |=> (q.st == ST_CMD && !flagAny) [*2])
    else $error("command step did not open the sequence");
  a_no_data_quiet: assert property (
    (q.st == ST_XFER && xfer == XF_NONE) |=>
      ($stable(dataOutLines) && $stable(q.result)))
    else $error("no-transfer instruction moved data");
  a_input_word: assert property (
    (q.st == ST_XFER && !q.cpu && xfer == XF_IN_A) |=>
      q.result == $past(sense(linesS, q.positive)))
    else $error("input word not returned");
  a_output_word: assert property (
    (q.st == ST_XFER && !q.cpu && xfer == XF_OUT_A) |=>
      dataOutLines == $past(sense(q.acc, q.positive)))
    else $error("output word not driven");
  a_skip_answer: assert property (
    (q.st == ST_XFER && !q.cpu && xfer == XF_SKIP) |=>
      q.skip == $past(skip_true(flagFn, q.busy, q.done)))
    else $error("skip answer wrong");
  a_reset_reload: assert property (
    (q.st == ST_XFER && q.cpu && xfer == XF_OUT_A && !setBusyS &&
     !setDoneS) |=> (!q.busy && !q.done && q.devCode == $past(jumpS)))
    else $error("bus reset did not reload");
  a_mask_load: assert property (
    (q.st == ST_XFER && q.cpu && xfer == XF_OUT_B) |=>
      q.intDisable == $past(|(sense(linesS, q.positive) & q.acc))
      ##1 (!intRequest || !q.intDisable))
    else $error("mask load wrong");
  a_ack_code: assert property (
    (q.st == ST_XFER && q.cpu && xfer == XF_IN_B) |=>
      q.result == ($past(q.intReq && noHigherRequest) ?
                   {10'h000, $past(q.devCode)} : 16'h0000))
    else $error("acknowledge answer wrong");
  a_done_request: assert property (
    (setDoneS && !setBusyS) |=> (q.done && !q.busy) ##1 intRequest ||
      q.intDisable)
    else $error("done request not taken");
  a_sync_request: assert property (
    (intSyncS && !q.intDisable && !setBusyS && !setDoneS &&
     q.st == ST_IDLE) |=> (q.syncPend && $stable(q.busy) &&
      $stable(q.done)) ##1 intRequest || q.intDisable)
    else $error("sync request mishandled");
  a_done_pending: assert property (
    $fell(q.done) && !q.syncPend |-> !intRequest)
    else $error("interrupt kept after done cleared");
  a_foreign_ignored: assert property (
    (q.st == ST_IDLE && instrWrite &&
     pwdata[`GPIOC_F_DEV] != q.devCode &&
     pwdata[`GPIOC_F_DEV] != `GPIOC_CPU_DEV) |=> q.st == ST_IDLE)
    else $error("foreign device code served");

  c_input_flow: cover property (
    q.st == ST_XFER && xfer == XF_IN_A ##1 q.strobes.specialPulseStrobe);
  c_mask_load: cover property (q.strobes.maskLoadStrobe ##[1:8]
    q.intDisable);
  c_ack_hit: cover property (q.st == ST_XFER && q.cpu &&
    xfer == XF_IN_B && q.intReq && noHigherRequest);
  c_skip_true: cover property (q.st == ST_XFER && xfer == XF_SKIP ##1
    q.skip);
endmodule

// [sim/gpioc_customer_model.sv]
`timescale 1ns/1ps
module gpioc_customer_model #(
  parameter logic [15:0] IN_A = 16'h5a3c,
  parameter logic [15:0] IN_B = 16'h0f0f,
  parameter logic [15:0] IN_C = 16'h9e17
) (
  // Clock
  input wire logic clk,
  // Controller side
  input wire gpioc_pkg::gpioc_strobe_type strobes,
  input wire logic [15:0] dataOutLines,
  input wire logic external,
  input wire logic [15:0] maskWord,
  output logic [15:0] dataInLines,
  // Loaded output registers
  output logic [15:0] loadA,
  output logic [15:0] loadB,
  output logic [15:0] loadC
);
  import gpioc_pkg::*;
  logic [2:0] wasOut = 3'h0;

  // ==========
  // Input group: open collector, so released lines sit at the pull-up
  always_comb begin
    dataInLines = 16'hffff;
    if (strobes.inputAStrobe) dataInLines = IN_A;
    if (strobes.inputBStrobe && external) dataInLines = IN_B;
    if (strobes.inputCStrobe) dataInLines = IN_C;
    if (strobes.maskLoadStrobe) dataInLines = maskWord;
  end

  // ==========
  // Output registers load once the strobe drops and the word has settled
  always @(posedge clk) begin
    wasOut <= strobes[6:4];
    if (wasOut[2] && !strobes[6]) loadA <= dataOutLines;
    if (wasOut[1] && !strobes[5]) loadB <= dataOutLines;
    if (wasOut[0] && !strobes[4]) loadC <= dataOutLines;
  end
endmodule

// [sim/general_purpose_io_controller_tb_top.sv]
`timescale 1ns/1ps
`include "gpioc_defines.svh"
module general_purpose_io_controller_tb_top;
  import gpioc_pkg::*;
  typedef struct packed {
    gpioc_xfer_type x;
    logic [1:0] f;
    logic [15:0] acc;
    logic [16:0] res;
    logic useRes;
    logic busy;
  } gpioc_row_type;
  localparam logic [5:0] DEV = 6'h0a;
  localparam logic [5:0] CPU = `GPIOC_CPU_DEV;
  localparam logic [15:0] IN_A = 16'h5a3c;
  localparam logic [15:0] IN_C = 16'h9e17;
  localparam logic [15:0] IN_B = 16'h0f0f;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, res;
  logic [15:0] dataOutLines, dataInLines, maskWord, loadA, loadB, loadC;
  gpioc_strobe_type strobes;
  logic setBusyReq, setDoneReq, intSyncReq, intRequest, noHigherRequest;
  logic [5:0] jumpers;
  logic outsideRegisterJumper, logicSenseJumper, channelAddressInternal;
  logic [14:0] channelAddress;
  logic [15:0] channelCount;
  logic [2:0] seen;
  int fail_count, checked, cyc;
  gpioc_row_type rows [11] = '{
    '{XF_NONE, 2'h1, 16'h1111, 17'h0, 1'b0, 1'b1},
    '{XF_IN_A, 2'h3, 16'h0, {1'b0, IN_A}, 1'b1, 1'b1},
    '{XF_OUT_A, 2'h2, 16'hc35a, 17'h0, 1'b0, 1'b0},
    '{XF_OUT_B, 2'h0, 16'hf00d, 17'h0, 1'b0, 1'b0},
    '{XF_IN_B, 2'h0, 16'h0, 17'h0700d, 1'b1, 1'b0},
    '{XF_OUT_C, 2'h1, 16'hbeef, 17'h0, 1'b0, 1'b1},
    '{XF_IN_C, 2'h0, 16'h0, {1'b0, IN_C}, 1'b1, 1'b1},
    '{XF_SKIP, 2'h0, 16'h0, 17'h10000, 1'b1, 1'b1},
    '{XF_SKIP, 2'h1, 16'h0, 17'h0, 1'b1, 1'b1},
    '{XF_SKIP, 2'h2, 16'h0, 17'h0, 1'b1, 1'b1},
    '{XF_SKIP, 2'h3, 16'h0, 17'h10000, 1'b1, 1'b1}
  };

  gpioc_controller gpioc_controller_inst (.clk(clk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataOutLines(dataOutLines), .dataInLines(dataInLines),
    .strobes(strobes), .setBusyReq(setBusyReq), .setDoneReq(setDoneReq),
    .intSyncReq(intSyncReq), .deviceCodeJumpers(jumpers),
    .outsideRegisterJumper(outsideRegisterJumper),
    .logicSenseJumper(logicSenseJumper), .noHigherRequest(noHigherRequest),
    .intRequest(intRequest), .channelAddress(channelAddress),
    .channelAddressInternal(channelAddressInternal),
    .channelCount(channelCount));
  gpioc_customer_model #(.IN_A(IN_A), .IN_B(IN_B), .IN_C(IN_C))
    gpioc_customer_model_inst (.clk(clk), .strobes(strobes),
    .dataOutLines(dataOutLines), .external(outsideRegisterJumper),
    .maskWord(maskWord), .dataInLines(dataInLines), .loadA(loadA),
    .loadB(loadB), .loadC(loadC));

  // ==========
  // Bench tasks
  task automatic stop_test;
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("unexpected value at %0t: got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Runs one instruction, waits for it to retire, fetches result and status
  task automatic io(input gpioc_xfer_type x, input logic [1:0] f,
                    input logic [5:0] d, input logic [15:0] a);
    seen = 3'h0;
    apb(1'b1, `GPIOC_ADDR_ACC, a);
    apb(1'b1, `GPIOC_ADDR_INSTR, {3'h3, 2'h0, x, f, d});
    do begin
      apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
    end while (rd[5] !== 1'b0);
    apb(1'b0, `GPIOC_ADDR_RESULT, 16'h0);
    res = rd;
    apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A flag strobe must never overlap a command or data strobe
  always @(posedge clk) begin
    cyc++;
    seen = seen | strobes[2:0];
    if (rstn && strobes[2:0] != 3'h0 && strobes[9:3] != 7'h0) begin
      chk(1, 0);
    end
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {setBusyReq, setDoneReq, intSyncReq, outsideRegisterJumper} = '0;
    logicSenseJumper = 1'b1;
    noHigherRequest = 1'b1;
    jumpers = DEV;
    maskWord = 16'h0004;
    seen = 3'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
    chk(rd, 32'h0a40);
    chk(channelAddressInternal, 1'b1);
    foreach (rows[i]) begin
      io(rows[i].x, rows[i].f, DEV, rows[i].acc);
      chk(rd[1:0], {1'b0, rows[i].busy});
      // Start, clear and pulse give one-hot 100, 010, 001 on the strobes
      chk(seen, rows[i].x == XF_SKIP ? 3'h0 :
          3'h4 >> (rows[i].f - 2'h1));
      if (rows[i].x == XF_SKIP) chk(res[16], rows[i].res[16]);
      else if (rows[i].useRes) chk(res[15:0], rows[i].res[15:0]);
      if (rows[i].x == XF_NONE) chk(dataOutLines, 16'h0);
    end
    chk(loadA, 16'hc35a);
    chk(loadB, 16'hf00d);
    chk(loadC, 16'hbeef);
    chk(channelAddress, 15'h700d);
    chk(channelCount, 16'hbeef);
    apb(1'b0, 8'h10, 16'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    io(XF_NONE, 2'h2, 6'h0b, 16'h0);
    chk({seen, rd[1:0]}, 5'b00001);
    setDoneReq <= 1'b1;
    repeat (5) @(posedge clk);
    setDoneReq <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
    chk({intRequest, rd[2:0]}, 4'b1110);
    io(XF_OUT_B, 2'h0, CPU, 16'h0006);
    chk({intRequest, rd[3]}, 2'b01);
    io(XF_OUT_B, 2'h0, CPU, 16'h0001);
    chk({intRequest, rd[3]}, 2'b10);
    setBusyReq <= 1'b1;
    repeat (5) @(posedge clk);
    setBusyReq <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
    chk(rd[0], 1'b1);
    io(XF_OUT_A, 2'h0, CPU, 16'h0);
    repeat (3) @(posedge clk);
    chk({intRequest, rd[13:8], rd[1:0]}, {1'b0, DEV, 2'b00});
    intSyncReq <= 1'b1;
    repeat (5) @(posedge clk);
    intSyncReq <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, `GPIOC_ADDR_STATUS, 16'h0);
    chk({intRequest, rd[1:0]}, 3'b100);
    noHigherRequest <= 1'b0;
    io(XF_IN_B, 2'h0, CPU, 16'h0);
    chk(res[15:0], 16'h0);
    noHigherRequest <= 1'b1;
    io(XF_IN_B, 2'h0, CPU, 16'h0);
    repeat (3) @(posedge clk);
    chk({intRequest, res[15:0]}, {1'b0, 10'h0, DEV});
    // New jumper setting only takes hold at the next bus reset
    jumpers <= 6'h15;
    logicSenseJumper <= 1'b0;
    outsideRegisterJumper <= 1'b1;
    io(XF_OUT_A, 2'h0, CPU, 16'h0);
    chk(rd[13:6], {6'h15, 2'b10});
    chk(channelAddressInternal, 1'b0);
    io(XF_IN_B, 2'h0, 6'h15, 16'h0);
    chk(res[15:0], 16'hf0f0);
    io(XF_OUT_A, 2'h0, 6'h15, 16'h1234);
    chk(loadA, 16'hedcb);
    stop_test();
  end
endmodule
